//--- hw/pta_clk_div.sv
`timescale 1ns/1ps
`default_nettype none
// square wave with a period of ratio clocks; ratio must be even
module pta_clk_div #(
	parameter int W = 10
) (
	input  wire logic         clk_sys,
	input  wire logic         sys_rst,
	input  wire logic [W-1:0] ratio,
	output var  logic         div_clk
);
	logic [W-1:0] cnt;
	wire  [W-1:0] half_m1 = (ratio >> 1) - 1'b1;

	// a ratio change takes effect at once, shortening or stretching the half-period in progress
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			cnt     <= '0;
			div_clk <= 1'b0;
		end else if (cnt >= half_m1) begin
			cnt     <= '0;
			div_clk <= ~div_clk;
		end else begin
			cnt <= cnt + 1'b1;
		end
	end
endmodule
`default_nettype wire

//--- hw/pta_pulse_gen.sv
`timescale 1ns/1ps
`default_nettype none
// delay then width, both in pattern clock cycles; a new start restarts the shot
module pta_pulse_gen #(
	parameter int W = 36
) (
	input  wire logic clk_sys,
	input  wire logic sys_rst,
	pta_pulse_if.gen  pif
);
	logic [W:0] cnt;
	logic       run;
	wire  [W:0] stop_at  = {1'b0, pif.delay} + {1'b0, pif.width};
	wire        in_win   = run && (cnt >= {1'b0, pif.delay}) && (cnt < stop_at);
	wire        finished = run && (cnt >= stop_at);

	// zero width never raises the pulse, which is how width 0 disables it
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			cnt       <= '0;
			run       <= 1'b0;
			pif.pulse <= 1'b0;
		end else begin
			pif.pulse <= in_win;
			if (pif.start) begin
				cnt <= '0;
				run <= 1'b1;
			end else if (finished) begin
				run <= 1'b0;
			end else if (run) begin
				cnt <= cnt + 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

//--- hw/pta_timing_out.sv
//Operation
//- aux output selects divided clock (ratio 4..512), sync marker or second burst pulse.
//- sync position 1..lcm(extended length,128)-135, 8-bit steps, for PRBS or programmable data.
//- lengths up to 511 bits extend to the smallest multiple reaching 512 bits.
//- mixed patterns place sync by block and row number, each 1..configured count.
//- second burst pulse delay and width each 0..burst cycle-128, 8-bit steps.
//- burst gating window width 128..burst cycle-128 after a settable delay.
//- repeat gating pulse period is pattern length rounded down to 128 multiple, or total mixed length for mixed.
//- repeat pulse width 128..lcm(extended length,128)-128 for PRBS, zero-subst, data.
//- non-mixed repeat width never above 34359738240 bits; counters sized for it.
//- mixed repeat width 128..total mixed length-128, at most 2415918976.
//- repeat pulse delay has the same range and step as its width.
`timescale 1ns/1ps
`default_nettype none
module pta_timing_out
	import pta_pkg::*;
(
	input  wire logic                       clk_sys,
	input  wire logic                       sys_rst,
	input  wire pta_pkg::pta_pat_t          pat_type,
	input  wire pta_pkg::pta_seq_t          seq_mode,
	input  wire logic [pta_pkg::PTA_CFG_W-1:0] pat_len_bits,
	input  wire logic                       cfg_load,
	input  wire logic                       pat_start,
	input  wire logic [pta_pkg::PTA_CFG_W-1:0] burst_cycle_bits,
	input  wire logic                       burst_start,
	input  wire logic [pta_pkg::PTA_CFG_W-1:0] mix_total_bits,
	input  wire logic [pta_pkg::PTA_BLK_W-1:0] mix_blocks,
	input  wire logic [pta_pkg::PTA_ROW_W-1:0] mix_rows,
	input  wire logic                       mix_row_start,
	input  wire logic [pta_pkg::PTA_BLK_W-1:0] mix_cur_block,
	input  wire logic [pta_pkg::PTA_ROW_W-1:0] mix_cur_row,
	input  wire logic                       aux_en,
	input  wire pta_pkg::pta_aux_sel_t      aux_sel,
	input  wire logic [pta_pkg::PTA_DIV_W-1:0] div_ratio,
	input  wire logic [pta_pkg::PTA_POS_W-1:0] sync_pos,
	input  wire logic [pta_pkg::PTA_BLK_W-1:0] mark_block,
	input  wire logic [pta_pkg::PTA_ROW_W-1:0] mark_row,
	input  wire logic [pta_pkg::PTA_CFG_W-1:0] b2_delay,
	input  wire logic [pta_pkg::PTA_CFG_W-1:0] b2_width,
	input  wire logic [pta_pkg::PTA_CFG_W-1:0] gw_delay,
	input  wire logic [pta_pkg::PTA_CFG_W-1:0] gw_width,
	input  wire logic                       gate_en,
	input  wire logic [pta_pkg::PTA_CFG_W-1:0] rp_delay,
	input  wire logic [pta_pkg::PTA_CFG_W-1:0] rp_width,
	output var  logic                       aux_out,
	output var  logic                       gate_out,
	output var  logic                       len_ready
);
	import pta_pkg::*;

	localparam int CW = PTA_CFG_W;
	localparam int LW = PTA_LCM_W;
	localparam int PW = PTA_POS_W;

	// lowest set bit position of a length, saturating at the 128-bit granularity
	function automatic logic [2:0] low_zeros(input logic [LW-1:0] v);
		logic [2:0] n;
		logic       seen;
		n    = 3'h0;
		seen = 1'b0;
		for (int i = 0; i < PTA_GRAN_SHIFT; i++) begin
			if (!seen && !v[i])
				n = n + 3'h1;
			else
				seen = 1'b1;
		end
		return n;
	endfunction

	// ---------------- extended length and alignment period ----------------
	pta_ext_state_t   ext_state;
	pta_ext_state_t   next_ext_state;
	logic [LW-1:0]    ext_len;
	logic [LW-1:0]    lcm_bits;
	wire  [LW-1:0]    len_w    = {{(LW-CW){1'b0}}, pat_len_bits};
	wire              ext_short = ext_len < PTA_EXT_MIN_BITS;
	wire  [2:0]       ext_tz    = low_zeros(ext_len);
	// lcm with 128 is the length scaled by the powers of two it lacks
	wire  [2:0]       lcm_sh    = 3'(PTA_GRAN_SHIFT) - ext_tz;
	wire  [LW-1:0]    next_lcm  = ext_len << lcm_sh;

	// next state of the length extension walk
	always_comb begin
		next_ext_state = ext_state;
		unique case (ext_state)
			PTA_EXT_IDLE: next_ext_state = PTA_EXT_GROW;
			PTA_EXT_GROW: if (!ext_short) next_ext_state = PTA_EXT_DONE;
			PTA_EXT_DONE: if (cfg_load) next_ext_state = PTA_EXT_IDLE;
		endcase
	end

	// repeated addition avoids a divider; at most 512 cycles for a 1-bit length
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			ext_state <= PTA_EXT_IDLE;
			ext_len   <= PTA_LCM_RST;
			lcm_bits  <= PTA_LCM_RST;
		end else begin
			ext_state <= next_ext_state;
			if (ext_state == PTA_EXT_IDLE)
				ext_len <= (len_w == '0) ? PTA_EXT_MIN_BITS : len_w;
			else if (ext_state == PTA_EXT_GROW && ext_short)
				ext_len <= ext_len + len_w;
			else if (ext_state == PTA_EXT_GROW)
				lcm_bits <= next_lcm;
		end
	end

	// ---------------- word counts, eight bits per clock ----------------
	wire [LW-1:0] lcm_words   = lcm_bits >> PTA_BPC_SHIFT;
	wire [LW-1:0] gran_words  = PTA_GRAN_BITS >> PTA_BPC_SHIFT;
	wire [LW-1:0] bc_words    = {{(LW-CW){1'b0}}, burst_cycle_bits} >> PTA_BPC_SHIFT;
	wire [LW-1:0] mix_words   = {{(LW-CW){1'b0}}, mix_total_bits} >> PTA_BPC_SHIFT;
	wire          is_mixed    = pat_type == PTA_PAT_MIXED;
	wire          is_burst    = seq_mode == PTA_SEQ_BURST;
	// cycle of the repeat pulse: length with the last partial 128 bits dropped
	wire [LW-1:0] rep_period  = ((len_w >> PTA_GRAN_SHIFT) << PTA_GRAN_SHIFT) >> PTA_BPC_SHIFT;
	wire [LW-1:0] rep_per_sel = is_mixed ? mix_words : rep_period;

	// ---------------- setting bounds ----------------
	wire [LW-1:0] bc_hi     = pta_sat_sub(bc_words, gran_words);
	wire [LW-1:0] sync_hi   = pta_sat_sub(lcm_bits, PTA_SYNC_TAIL) >> PTA_BPC_SHIFT;
	wire [LW-1:0] nm_span   = pta_sat_sub(lcm_bits, PTA_GRAN_BITS);
	wire [LW-1:0] nm_hi_b   = (nm_span > PTA_NONMIX_MAX) ? PTA_NONMIX_MAX : nm_span;
	wire [LW-1:0] mx_span   = pta_sat_sub({{(LW-CW){1'b0}}, mix_total_bits}, PTA_GRAN_BITS);
	wire [LW-1:0] mx_hi_b   = (mx_span > PTA_MIX_MAX) ? PTA_MIX_MAX : mx_span;
	wire [LW-1:0] rp_hi     = (is_mixed ? mx_hi_b : nm_hi_b) >> PTA_BPC_SHIFT;

	wire [LW-1:0] b2_d_eff  = pta_clamp({{(LW-CW){1'b0}}, b2_delay}, '0, bc_hi);
	wire [LW-1:0] b2_w_eff  = pta_clamp({{(LW-CW){1'b0}}, b2_width}, '0, bc_hi);
	wire [LW-1:0] gw_d_eff  = pta_clamp({{(LW-CW){1'b0}}, gw_delay}, '0, bc_hi);
	wire [LW-1:0] gw_w_eff  = pta_clamp({{(LW-CW){1'b0}}, gw_width}, gran_words, bc_hi);
	wire [LW-1:0] rp_w_eff  = pta_clamp({{(LW-CW){1'b0}}, rp_width}, gran_words, rp_hi);
	wire [LW-1:0] rp_d_eff  = pta_clamp({{(LW-CW){1'b0}}, rp_delay}, gran_words, rp_hi);
	wire [LW-1:0] pos_eff   = pta_clamp({{(LW-PW){1'b0}}, sync_pos}, '0, sync_hi);

	// ---------------- alignment and sync marker counter ----------------
	logic          aligned;
	logic [PW-1:0] sync_cnt;
	logic [LW-1:0] rep_cnt;
	logic          rep_tick;
	logic          sync_mark;
	wire  [PW-1:0] sync_last = PW'(lcm_words - 1'b1);
	wire           sync_wrap = sync_cnt >= sync_last;
	wire           rep_wrap  = rep_cnt >= (rep_per_sel - 1'b1);
	wire           sync_hit  = aligned && (sync_cnt == PW'(pos_eff));

	// the first pattern start after a length change aligns both counters
	always_ff @(posedge clk_sys) begin
		if (sys_rst || cfg_load)
			aligned <= 1'b0;
		else if (pat_start && len_ready)
			aligned <= 1'b1;
	end

	// position counter over one alignment period; marker is one cycle wide
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			sync_cnt  <= PTA_POS_RST;
			sync_mark <= 1'b0;
		end else begin
			sync_mark <= sync_hit;
			if (!aligned || sync_wrap)
				sync_cnt <= '0;
			else
				sync_cnt <= sync_cnt + 1'b1;
		end
	end

	// repeat period counter; a zero period leaves the tick idle
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			rep_cnt  <= '0;
			rep_tick <= 1'b0;
		end else begin
			rep_tick <= aligned && (rep_cnt == '0) && (rep_per_sel != '0);
			if (!aligned || rep_wrap)
				rep_cnt <= '0;
			else
				rep_cnt <= rep_cnt + 1'b1;
		end
	end

	// ---------------- mixed block and row marker ----------------
	wire [PTA_BLK_W-1:0] blk_lo  = PTA_BLK_W'(1);
	wire [PTA_ROW_W-1:0] row_lo  = PTA_ROW_W'(1);
	wire [PTA_BLK_W-1:0] blk_eff = (mark_block < blk_lo) ? blk_lo :
		(mark_block > mix_blocks) ? mix_blocks : mark_block;
	wire [PTA_ROW_W-1:0] row_eff = (mark_row < row_lo) ? row_lo :
		(mark_row > mix_rows) ? mix_rows : mark_row;
	logic                mix_mark;

	// marks the start of the chosen row inside the chosen block
	always_ff @(posedge clk_sys) begin
		if (sys_rst)
			mix_mark <= 1'b0;
		else
			mix_mark <= mix_row_start && (mix_cur_block == blk_eff) && (mix_cur_row == row_eff);
	end

	// ---------------- pulse channels ----------------
	pta_pulse_if #(.W(LW)) b2_if ();
	pta_pulse_if #(.W(LW)) gw_if ();
	pta_pulse_if #(.W(LW)) rp_if ();

	// burst channels restart every burst cycle, repeat channel every period
	assign b2_if.start = burst_start;
	assign b2_if.delay = b2_d_eff;
	assign b2_if.width = b2_w_eff;
	assign gw_if.start = burst_start && is_burst;
	assign gw_if.delay = gw_d_eff;
	assign gw_if.width = gw_w_eff;
	assign rp_if.start = rep_tick && !is_burst;
	assign rp_if.delay = rp_d_eff;
	assign rp_if.width = rp_w_eff;

	pta_pulse_gen #(.W(LW)) u_b2 (
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.pif     (b2_if.gen)
	);

	pta_pulse_gen #(.W(LW)) u_gw (
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.pif     (gw_if.gen)
	);

	pta_pulse_gen #(.W(LW)) u_rp (
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.pif     (rp_if.gen)
	);

	// ---------------- divided clock ----------------
	// odd ratios are rounded down to even so the wave stays symmetric
	wire [PTA_DIV_W-1:0] div_even = {div_ratio[PTA_DIV_W-1:1], 1'b0};
	wire [PTA_DIV_W-1:0] div_eff  = (div_even < PTA_DIV_MIN) ? PTA_DIV_MIN :
		(div_even > PTA_DIV_MAX) ? PTA_DIV_MAX : div_even;
	logic                div_clk;

	pta_clk_div #(.W(PTA_DIV_W)) u_div (
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.ratio   (div_eff),
		.div_clk (div_clk)
	);

	// ---------------- output selection ----------------
	wire sync_src = is_mixed ? mix_mark : sync_mark;
	wire aux_pick = (aux_sel == PTA_AUX_CLK)  ? div_clk :
		(aux_sel == PTA_AUX_SYNC) ? sync_src : b2_if.pulse;
	wire gate_pick = is_burst ? gw_if.pulse : rp_if.pulse;

	// every output leaves from a flop; disabled outputs sit low
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			aux_out   <= 1'b0;
			gate_out  <= 1'b0;
			len_ready <= 1'b0;
		end else begin
			aux_out   <= aux_en && aux_pick;
			gate_out  <= gate_en && gate_pick;
			len_ready <= next_ext_state == PTA_EXT_DONE;
		end
	end
endmodule
`default_nettype wire

//--- pkg/pta_pkg.sv
package pta_pkg;
	// the parallel pattern clock carries eight bits per cycle
	localparam int PTA_BITS_PER_CLK = 8;
	localparam int PTA_BPC_SHIFT    = 3;
	localparam int PTA_CFG_W        = 32;
	localparam int PTA_LCM_W        = 40;
	localparam int PTA_POS_W        = 36;
	localparam int PTA_DIV_W        = 10;
	localparam int PTA_BLK_W        = 9;
	localparam int PTA_ROW_W        = 5;
	// granularity and limits, all in bits
	localparam logic [PTA_LCM_W-1:0] PTA_GRAN_BITS    = 40'h00_0000_0080;
	localparam int                   PTA_GRAN_SHIFT   = 7;
	localparam logic [PTA_LCM_W-1:0] PTA_SYNC_TAIL    = 40'h00_0000_0088;
	localparam logic [PTA_LCM_W-1:0] PTA_EXT_MIN_BITS = 40'h00_0000_0200;
	localparam logic [PTA_LCM_W-1:0] PTA_NONMIX_MAX   = 40'h07_FFFF_FF80;
	localparam logic [PTA_LCM_W-1:0] PTA_MIX_MAX      = 40'h00_8FFF_FF80;
	// divider ratio limits
	localparam logic [PTA_DIV_W-1:0] PTA_DIV_MIN = 10'h004;
	localparam logic [PTA_DIV_W-1:0] PTA_DIV_MAX = 10'h200;
	// reset values
	localparam logic [PTA_LCM_W-1:0] PTA_LCM_RST  = 40'h00_0000_0200;
	localparam logic [PTA_POS_W-1:0] PTA_POS_RST  = 36'h0_0000_0000;

	typedef enum logic [1:0] {PTA_AUX_CLK, PTA_AUX_SYNC, PTA_AUX_BURST2} pta_aux_sel_t;
	typedef enum logic [2:0] {PTA_PAT_PRBS, PTA_PAT_ZSUB, PTA_PAT_DATA, PTA_PAT_PROG, PTA_PAT_MIXED} pta_pat_t;
	typedef enum logic {PTA_SEQ_REPEAT, PTA_SEQ_BURST} pta_seq_t;
	typedef enum logic [1:0] {PTA_EXT_IDLE, PTA_EXT_GROW, PTA_EXT_DONE} pta_ext_state_t;

	// bounds a setting to [lo, hi]; hi below lo yields lo
	function automatic logic [PTA_LCM_W-1:0] pta_clamp(input logic [PTA_LCM_W-1:0] v,
		input logic [PTA_LCM_W-1:0] lo, input logic [PTA_LCM_W-1:0] hi);
		logic [PTA_LCM_W-1:0] r;
		r = v;
		if (v > hi)
			r = hi;
		if (r < lo)
			r = lo;
		return r;
	endfunction

	// subtraction that stops at zero
	function automatic logic [PTA_LCM_W-1:0] pta_sat_sub(input logic [PTA_LCM_W-1:0] a,
		input logic [PTA_LCM_W-1:0] b);
		return (a > b) ? (a - b) : '0;
	endfunction
endpackage

//--- pkg/pta_pulse_if.sv
`timescale 1ns/1ps
`default_nettype none
// one delayed pulse channel between the controller and a pulse generator
interface pta_pulse_if #(parameter int W = 36);
	logic         start;
	logic [W-1:0] delay;
	logic [W-1:0] width;
	logic         pulse;
	modport gen (input start, input delay, input width, output pulse);
	modport ctl (output start, output delay, output width, input pulse);
endinterface
`default_nettype wire

//--- test/pta_far_end.sv
`timescale 1ns/1ps
`default_nettype none
// far-end instrument: times the high run and the rise-to-rise period of one line
module pta_far_end (
	input  wire logic        clk_sys,
	input  wire logic        line,
	output var  logic [31:0] hi_len,
	output var  logic [31:0] period,
	output wire logic [31:0] n_fall
);
	logic [31:0] run  = '0;
	logic [31:0] last = '0;
	logic [31:0] hi   = '0;
	logic [31:0] nf   = '0;
	logic        prev = 1'h0;
	assign n_fall = nf;
	// the first period after a reset is bogus, so callers wait for several edges
	always_ff @(posedge clk_sys) begin
		run  <= run + 32'h1;
		prev <= line;
		hi   <= line ? hi + 32'h1 : '0;
		if (line && !prev) begin
			period <= run - last;
			last   <= run;
		end
		if (!line && prev) begin
			hi_len <= hi;
			nf     <= nf + 32'h1;
		end
	end
endmodule
`default_nettype wire

//--- test/pta_timing_properties.sv
`timescale 1ns/1ps
`default_nettype none
// watches the timing outputs against their settings
module pta_timing_props
	import pta_pkg::*;
(
	input  wire logic                          clk_sys,
	input  wire logic                          sys_rst,
	input  wire pta_pkg::pta_seq_t             seq_mode,
	input  wire logic                          cfg_load,
	input  wire logic [pta_pkg::PTA_CFG_W-1:0] burst_cycle_bits,
	input  wire logic                          burst_start,
	input  wire logic                          aux_en,
	input  wire pta_pkg::pta_aux_sel_t         aux_sel,
	input  wire logic [pta_pkg::PTA_DIV_W-1:0] div_ratio,
	input  wire logic [pta_pkg::PTA_CFG_W-1:0] b2_delay,
	input  wire logic [pta_pkg::PTA_CFG_W-1:0] b2_width,
	input  wire logic [pta_pkg::PTA_CFG_W-1:0] gw_delay,
	input  wire logic [pta_pkg::PTA_CFG_W-1:0] gw_width,
	input  wire logic                          gate_en,
	input  wire logic [pta_pkg::PTA_CFG_W-1:0] rp_width,
	input  wire logic                          aux_out,
	input  wire logic                          gate_out,
	input  wire logic                          len_ready
);
	logic [31:0] scnt;
	logic [31:0] ahi;
	logic [31:0] ghi;
	// clamped settings; the shot may start at either of two edges, so delays allow one cycle of play
	wire  [31:0] bhi = (burst_cycle_bits >> 3) - 32'h10;
	wire  [31:0] b2d = (b2_delay > bhi) ? bhi : b2_delay;
	wire  [31:0] b2w = (b2_width > bhi) ? bhi : b2_width;
	wire  [31:0] gwd = (gw_delay > bhi) ? bhi : gw_delay;
	wire  [31:0] gww = (gw_width > bhi) ? bhi : (gw_width < 32'h10) ? 32'h10 : gw_width;
	wire         b2m = aux_en && aux_sel == PTA_AUX_BURST2;
	wire         gbm = gate_en && seq_mode == PTA_SEQ_BURST;
	// cycles since a burst start, and the running high count of each output
	always_ff @(posedge clk_sys) begin
		scnt <= (sys_rst || burst_start) ? '0 : scnt + 32'h1;
		ahi  <= (sys_rst || !aux_out) ? '0 : ahi + 32'h1;
		ghi  <= (sys_rst || !gate_out) ? '0 : ghi + 32'h1;
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	a_load_drops_ready: assert property (cfg_load && len_ready |=> !len_ready)
		else $error("len_ready held after cfg_load");
	a_ready_comes_back: assert property ($fell(len_ready) |-> ##[1:520] len_ready)
		else $error("len_ready did not return");
	a_div_half_period: assert property (aux_en && aux_sel == PTA_AUX_CLK && $fell(aux_out) |-> ahi == {23'h0, div_ratio[9:1]})
		else $error("divider high time wrong");
	a_sync_one_cycle: assert property (aux_en && aux_sel == PTA_AUX_SYNC && $fell(aux_out) |-> ahi == 32'h1)
		else $error("sync marker not one cycle");
	a_b2_delay_exact: assert property (b2m && $rose(aux_out) |-> (scnt - b2d) inside {32'h2, 32'h3})
		else $error("second burst pulse delay wrong");
	a_b2_width_exact: assert property (b2m && $fell(aux_out) |-> ahi == b2w)
		else $error("second burst pulse width wrong");
	a_gate_delay_exact: assert property (gbm && $rose(gate_out) |-> (scnt - gwd) inside {32'h2, 32'h3})
		else $error("gating window delay wrong");
	a_gate_width_exact: assert property (gbm && $fell(gate_out) |-> ghi == gww)
		else $error("gating window width wrong");
	a_repeat_width: assert property (gate_en && seq_mode == PTA_SEQ_REPEAT && $fell(gate_out) |-> ghi == rp_width)
		else $error("repeat pulse width wrong");
	c_b2_pulse: cover property (b2m && $fell(aux_out));
	c_repeat_pulse: cover property (gate_en && seq_mode == PTA_SEQ_REPEAT && $fell(gate_out));
	c_len_ready: cover property ($rose(len_ready));
endmodule
bind pta_timing_out pta_timing_props u_props (.clk_sys, .sys_rst, .seq_mode, .cfg_load, .burst_cycle_bits,
	.burst_start, .aux_en, .aux_sel, .div_ratio, .b2_delay, .b2_width, .gw_delay, .gw_width, .gate_en, .rp_width,
	.aux_out, .gate_out, .len_ready);
`default_nettype wire

//--- test/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import pta_pkg::*;
	logic                 clk_sys = 1'h0, sys_rst = 1'h1, cfg_load = 1'h0, pat_start = 1'h0, burst_start = 1'h0;
	logic                 mix_row_start = 1'h0, aux_en = 1'h0, gate_en = 1'h0, aux_out, gate_out, len_ready;
	logic [31:0]          pat_len_bits = 32'h200, burst_cycle_bits = 32'h6400, mix_total_bits = '0, rp_delay = 32'h10;
	logic [31:0]          b2_delay = '0, b2_width = '0, gw_delay = '0, gw_width = 32'h10, rp_width = 32'h10;
	logic [31:0]          a_hi, a_per, a_nf, g_hi, g_per, g_nf, n0, n_mismatch = '0, checks = '0;
	logic [8:0]           mix_blocks = 9'h1, mix_cur_block = 9'h1, mark_block = 9'h1;
	logic [4:0]           mix_rows = 5'h1, mix_cur_row = 5'h1, mark_row = 5'h1;
	logic [9:0]           div_ratio = 10'h4;
	logic [35:0]          sync_pos = '0;
	pta_pat_t             pat_type = PTA_PAT_PRBS;
	pta_seq_t             seq_mode = PTA_SEQ_REPEAT;
	pta_aux_sel_t         aux_sel = PTA_AUX_CLK;
	logic [9:0]           ratios [3] = '{10'h4, 10'h8, 10'h200};
	// burst table: delay, width, expected second pulse and expected gating window (min width 16)
	logic [31:0]          bd [4] = '{32'h0, 32'hC70, 32'h5, 32'h2};
	logic [31:0]          bw [4] = '{32'h3, 32'h1, 32'hFA0, 32'h0};
	logic [31:0]          ea [4] = '{32'h3, 32'h1, 32'hC70, 32'h0};
	logic [31:0]          eg [4] = '{32'h10, 32'h10, 32'hC70, 32'h10};

	pta_timing_out u_dut (.clk_sys, .sys_rst, .pat_type, .seq_mode, .pat_len_bits, .cfg_load, .pat_start,
		.burst_cycle_bits, .burst_start, .mix_total_bits, .mix_blocks, .mix_rows, .mix_row_start, .mix_cur_block,
		.mix_cur_row, .aux_en, .aux_sel, .div_ratio, .sync_pos, .mark_block, .mark_row, .b2_delay, .b2_width,
		.gw_delay, .gw_width, .gate_en, .rp_delay, .rp_width, .aux_out, .gate_out, .len_ready);
	pta_far_end u_aux_end (.clk_sys, .line(aux_out), .hi_len(a_hi), .period(a_per), .n_fall(a_nf));
	pta_far_end u_gate_end (.clk_sys, .line(gate_out), .hi_len(g_hi), .period(g_per), .n_fall(g_nf));

	initial forever #5 clk_sys = ~clk_sys;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic end_of_test;
		if (n_mismatch == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// bounded waits, sampled mid-cycle where outputs have settled
	task automatic wait_falls(input logic gate, input int k);
		n0 = gate ? g_nf : a_nf;
		for (int i = 0; i < 40000; i++) begin
			@(negedge clk_sys);
			if ((gate ? g_nf : a_nf) >= n0 + k)
				return;
		end
		n_mismatch++;
		end_of_test;
	endtask
	task automatic wait_ready;
		for (int i = 0; i < 600; i++) begin
			@(negedge clk_sys);
			if (len_ready === 1'h1)
				return;
		end
		n_mismatch++;
		end_of_test;
	endtask
	// settings change under reset, so no half-done pulse spills into the next case
	task automatic restart;
		sys_rst <= 1'h1;
		repeat (6) @(posedge clk_sys);
		sys_rst <= 1'h0;
	endtask
	// reload the length, then mark the pattern start
	task automatic align;
		wait_ready;
		@(posedge clk_sys) cfg_load <= 1'h1;
		@(posedge clk_sys) cfg_load <= 1'h0;
		repeat (2) @(posedge clk_sys);
		wait_ready;
		@(posedge clk_sys) pat_start <= 1'h1;
		@(posedge clk_sys) pat_start <= 1'h0;
	endtask

	initial begin
		// divider at both ends of its range
		foreach (ratios[i]) begin
			@(posedge clk_sys);
			aux_en <= 1'h1;
			div_ratio <= ratios[i];
			restart;
			wait_falls(1'h0, 3);
			chk(a_per, {22'h0, ratios[i]});
			chk(a_hi, {23'h0, ratios[i][9:1]});
		end
		// 127-bit pattern extends to 635 bits, so the marker recurs every 10160 words; last legal position
		@(posedge clk_sys);
		aux_sel <= PTA_AUX_SYNC;
		pat_len_bits <= 32'h7F;
		sync_pos <= 36'h279F;
		restart;
		align;
		wait_falls(1'h0, 3);
		chk(a_per, 32'h27B0);
		chk(a_hi, 32'h1);
		// mixed marker by block and row
		@(posedge clk_sys);
		pat_type <= PTA_PAT_MIXED;
		mix_blocks <= 9'h3;
		mix_rows <= 5'h2;
		mark_block <= 9'h2;
		mix_cur_block <= 9'h2;
		mix_total_bits <= 32'hC000;
		restart;
		align;
		@(posedge clk_sys) mix_row_start <= 1'h1;
		@(posedge clk_sys) mix_row_start <= 1'h0;
		wait_falls(1'h0, 1);
		chk(a_hi, 32'h1);
		// repeat gating on a 1000-bit data pattern: period 112 words
		@(posedge clk_sys);
		pat_type <= PTA_PAT_DATA;
		pat_len_bits <= 32'h3E8;
		gate_en <= 1'h1;
		rp_width <= 32'h14;
		restart;
		align;
		wait_falls(1'h1, 3);
		chk(g_per, 32'h70);
		chk(g_hi, 32'h14);
		// burst shots on both outputs, including clamped and zero widths
		@(posedge clk_sys);
		seq_mode <= PTA_SEQ_BURST;
		aux_sel <= PTA_AUX_BURST2;
		restart;
		align;
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_sys);
			b2_delay <= bd[i];
			gw_delay <= bd[i];
			b2_width <= bw[i];
			gw_width <= bw[i];
			@(posedge clk_sys) burst_start <= 1'h1;
			@(posedge clk_sys) burst_start <= 1'h0;
			wait_falls(1'h1, 1);
			repeat (4) @(negedge clk_sys);
			chk(g_hi, eg[i]);
			if (bw[i] != 32'h0)
				chk(a_hi, ea[i]);
		end
		end_of_test;
	end
endmodule
`default_nettype wire
